// ### srs_button_model.sv
// Purpose: push-button model facing the supervisor
// Assumes: button shorts the line to ground, pull-up holds it high otherwise
// Notes: a press may bounce with one-cycle lows before the real hold
`timescale 1ns/1ps
module srs_button_model (
    input  wire logic clk_sys,              // system clock
    output logic      pushbutton_reset_in_n // button line, low = pressed
);
    // released line sits at the pull-up level
    initial pushbutton_reset_in_n = 1'b1;
    // bounce, then hold low for hold cycles; caller is just past an edge
    task automatic press(input int bounce, input int hold);
        repeat (bounce)
        begin
            pushbutton_reset_in_n = 1'b0;
            @(posedge clk_sys);
            #1 pushbutton_reset_in_n = 1'b1;
            @(posedge clk_sys);
            #1;
        end
        pushbutton_reset_in_n = 1'b0;
        repeat (hold) @(posedge clk_sys);
        #1 pushbutton_reset_in_n = 1'b1;
    endtask
endmodule // srs_button_model

// ### srs_consts.svh
// Purpose: constants for the supply reset supervisor
// Assumes: clk_sys at 125 MHz
// Notes: times in their own unit, cycle counts derived
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
`define SRS_CLK_MHZ         125
`define SRS_RELEASE_MS      200
`define SRS_RELEASE_CYC     (`SRS_RELEASE_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_DEBOUNCE_US     10
`define SRS_DEBOUNCE_CYC    (`SRS_DEBOUNCE_US * `SRS_CLK_MHZ)
`define SRS_SEL_PINS        3
`define SRS_LEVEL_LOW       2'h0
`define SRS_LEVEL_HIGH      2'h1
`define SRS_LEVEL_FLOAT     2'h2
`endif

// ### srs_pkg.sv
// Purpose: types for the supply reset supervisor
// Assumes: nothing
// Notes: select pin levels carried as a packed struct
package srs_pkg;
    typedef struct packed {
        logic [1:0] sel3;
        logic [1:0] sel2;
        logic [1:0] sel1;
    } srs_select_type;

    typedef enum logic [1:0] {
        SRS_HOLD    = 2'b00,
        SRS_TIMEOUT = 2'b01,
        SRS_RUN     = 2'b10
    } srs_state_type;
endpackage

// ### srs_supervisor.sv
// Purpose: reset supervisor: supply trip, debounced push-button, release time-out
// Assumes: comparator result and pin levels arrive synchronous to clk_sys
// Notes: the analog trip compare is outside; this block picks the trip code
`timescale 1ns/1ps
`include "srs_consts.svh"

// Summary of operation
// RL1 - reset output low whenever supply is below the selected trip level
// RL2 - release reset only after supply stays good for the full time-out
// RL3 - trip level comes from three select pins, each high, low or floating
// RL4 - system must not change select strapping while powered
// RL5 - reset held low from power-up until threshold and time-out release it
// RL6 - push-button input is active low and debounced into one clean request
// RL7 - push-button must stay low at least 10 us to be recognised
// RL8 - after push-button release, reset stays low for the time-out
// RL9 - any cause returning during the time-out restarts it from zero
module srs_supervisor #(
    parameter int RELEASE_CYC  = `SRS_RELEASE_CYC,
    parameter int DEBOUNCE_CYC = `SRS_DEBOUNCE_CYC
) (
    input  wire logic                   clk_sys,               // system clock
    input  wire logic                   rst_b,                 // sync reset, low active
    input  wire logic                   supply_below_trip,     // comparator: supply low
    input  wire logic                   pushbutton_reset_in_n, // push-button, low active
    input  wire srs_pkg::srs_select_type trip_select_pin,      // three-level strapping
    output logic [4:0]                  trip_code,             // selected threshold code
    output logic                        trip_code_valid,       // code not reserved
    output logic                        sys_reset_n            // reset output, low active
);
    import srs_pkg::*;

    // refuse counts that the sequencer and the debouncer cannot serve
    if (RELEASE_CYC < 2 || DEBOUNCE_CYC < 1)
    begin : g_bad_counts
        $error("srs_supervisor: counts too small");
    end

    srs_state_type state_r;
    logic [31:0]   tmo_r;
    logic [31:0]   deb_r;
    logic          button_req_r;
    logic          cause;
    logic [4:0]    code_nxt;
    logic          latched_r;
    logic [31:0]   low_run_r;
    logic [31:0]   clear_run_r;

    // base-3 code of the three select pins, low pin least significant
    function automatic logic [1:0] srs_digit(input logic [1:0] lvl);
        unique case (lvl)
            `SRS_LEVEL_LOW:   srs_digit = 2'h0;
            `SRS_LEVEL_FLOAT: srs_digit = 2'h1;
            `SRS_LEVEL_HIGH:  srs_digit = 2'h2;
            default:          srs_digit = 2'h1;
        endcase
    endfunction

    always_comb
    begin
        code_nxt = 5'(srs_digit(trip_select_pin.sel1))                 // RL3
                 + 5'(3 * srs_digit(trip_select_pin.sel2))
                 + 5'(9 * srs_digit(trip_select_pin.sel3));
    end

    // strapping caught once after reset release; later changes are ignored
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            latched_r       <= 1'b0;
            trip_code       <= 5'h0;
            trip_code_valid <= 1'b0;
        end
        else if (!latched_r)
        begin
            latched_r       <= 1'b1;                                    // RL4
            trip_code       <= code_nxt;                                // RL3
            trip_code_valid <= (code_nxt != 5'h1a);
        end
    end

    // debounce: request only after the button stays low the full window
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            deb_r        <= 32'h0;
            button_req_r <= 1'b0;
        end
        else if (pushbutton_reset_in_n)
        begin
            deb_r        <= 32'h0;                                      // RL6
            button_req_r <= 1'b0;
        end
        else if (deb_r >= 32'(DEBOUNCE_CYC - 1))
            button_req_r <= 1'b1;                                       // RL7
        else
            deb_r <= deb_r + 32'h1;
    end

    // any reset cause: low supply or a debounced button request
    assign cause = supply_below_trip | button_req_r;

    // release sequencer: hold, time-out, run
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state_r <= SRS_HOLD;                                        // RL5
            tmo_r   <= 32'h0;
        end
        else
        begin
            unique case (state_r)
                SRS_HOLD:
                begin
                    tmo_r <= 32'h0;
                    if (!cause)
                        state_r <= SRS_TIMEOUT;
                end
                SRS_TIMEOUT:
                begin
                    if (cause)
                    begin
                        state_r <= SRS_HOLD;                            // RL9
                        tmo_r   <= 32'h0;
                    end
                    else if (tmo_r >= 32'(RELEASE_CYC - 2))
                        state_r <= SRS_RUN;                             // RL2 RL8
                    else
                        tmo_r <= tmo_r + 32'h1;
                end
                SRS_RUN:
                begin
                    if (cause)
                        state_r <= SRS_HOLD;                            // RL1
                end
                default:
                    state_r <= SRS_HOLD;
            endcase
        end
    end

    // reset output, combinational so a low supply asserts at once
    assign sys_reset_n = (state_r == SRS_RUN) && !cause;                // RL1

    sequence s_cause_clears;
        cause ##1 !cause;
    endsequence

    a_low_supply_asserts: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
        supply_below_trip |-> !sys_reset_n)
        else $error("reset not asserted on low supply");

    a_release_not_early: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2
        s_cause_clears |-> !sys_reset_n [*8])
        else $error("reset released too early");

    a_restart_on_cause: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL9
        (state_r == SRS_TIMEOUT && cause) |=> (state_r == SRS_HOLD && tmo_r == 32'h0))
        else $error("time-out not restarted");

    a_debounce_min: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
        $rose(button_req_r) |-> !$past(pushbutton_reset_in_n, 1))
        else $error("button request without low input");

    a_bounce_drops: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL6
        pushbutton_reset_in_n |=> !button_req_r)
        else $error("request survived release");

    a_button_holds: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
        button_req_r |-> !sys_reset_n)
        else $error("reset released during button");

    a_power_up_hold: assert property (@(posedge clk_sys) // RL5
        !rst_b |=> !sys_reset_n)
        else $error("reset not held after power-up");

    a_strap_frozen: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL4
        latched_r && $past(latched_r) |-> $stable(trip_code))
        else $error("trip code changed after capture");

    // helper: consecutive edges that sampled the button line low
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || pushbutton_reset_in_n)
            low_run_r <= 32'h0;
        else if (low_run_r != 32'hffff_ffff)
            low_run_r <= low_run_r + 32'h1;
    end

    // helper: consecutive edges that sampled no reset cause
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || cause)
            clear_run_r <= 32'h0;
        else if (clear_run_r != 32'hffff_ffff)
            clear_run_r <= clear_run_r + 32'h1;
    end

    sequence s_button_held;
        low_run_r >= 32'(DEBOUNCE_CYC);
    endsequence

    a_debounce_full: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
        $rose(button_req_r) |-> s_button_held)
        else $error("button request before full low window");

    a_debounce_prompt: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL7
        s_button_held |-> button_req_r)
        else $error("held button not recognised");

    a_release_exact: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2 RL8
        $rose(sys_reset_n) |-> clear_run_r == 32'(RELEASE_CYC))
        else $error("reset released off the time-out");

    a_release_guard: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL2
        sys_reset_n |-> clear_run_r >= 32'(RELEASE_CYC))
        else $error("reset released before time-out");

    a_run_drops: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL1
        (state_r == SRS_RUN && cause) |=> state_r == SRS_HOLD)
        else $error("cause in run did not return to hold");
endmodule // srs_supervisor

// ### srs_supervisor_tb_top.sv
// Purpose: self-checking bench for the supply reset supervisor
// Assumes: short counts set through parameters
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module srs_supervisor_tb_top;
    import srs_pkg::*;
    localparam int REL = 20;
    localparam int DEB = 5;
    logic           clk_sys = 1'b0;
    logic           rst_b = 1'b0;
    logic           supply_below_trip = 1'b1;
    logic           pushbutton_reset_in_n;
    srs_select_type trip_select_pin = '0;
    logic [4:0]     trip_code;
    logic           trip_code_valid;
    logic           sys_reset_n;
    int             miscompares = 0;
    int             samples_checked = 0;
    int             exp;

    srs_supervisor #(.RELEASE_CYC(REL), .DEBOUNCE_CYC(DEB)) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .supply_below_trip(supply_below_trip),
        .pushbutton_reset_in_n(pushbutton_reset_in_n), .trip_select_pin(trip_select_pin),
        .trip_code(trip_code), .trip_code_valid(trip_code_valid), .sys_reset_n(sys_reset_n));
    srs_button_model i_btn (.clk_sys(clk_sys), .pushbutton_reset_in_n(pushbutton_reset_in_n));

    // 125 MHz clock
    initial forever #4 clk_sys = ~clk_sys;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (!ok)
        begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // pin level to digit: low 0, float 1, high 2
    function automatic int lvl(input logic [1:0] v);
        return (v == 2'h0) ? 0 : (v == 2'h1) ? 2 : 1;
    endfunction
    // cycles until reset output rises, bounded
    task automatic rel_chk(input int lo, input int hi);
        int n;
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
        chk(n >= lo && n <= hi, "release time");
    endtask
    // every strap pattern captured after a reset
    task automatic t_straps();
        for (int s = 0; s < 64; s++)
        begin
            trip_select_pin = s[5:0];
            rst_b = 1'b0;
            tick(2);
            chk(sys_reset_n === 1'b0, "reset out during reset");
            rst_b = 1'b1;
            tick(2);
            exp = lvl(s[1:0]) + 3 * lvl(s[3:2]) + 9 * lvl(s[5:4]);
            chk(trip_code === exp[4:0], "trip code");
            chk(trip_code_valid === (exp != 26), "trip code valid");
        end
    endtask
    // power-up, brownout and restart of the time-out
    task automatic t_supply();
        supply_below_trip = 1'b0;
        rel_chk(REL, REL);
        supply_below_trip = 1'b1;
        #1 chk(sys_reset_n === 1'b0, "immediate assert");
        tick(3);
        supply_below_trip = 1'b0;
        tick(REL / 2);
        supply_below_trip = 1'b1;
        tick(1);
        supply_below_trip = 1'b0;
        rel_chk(REL, REL);
    endtask
    // short bouncing press ignored, long one gives one reset
    task automatic t_button();
        i_btn.press(3, DEB - 2);
        tick(2);
        chk(sys_reset_n === 1'b1, "short press ignored");
        i_btn.press(3, DEB + 3);
        chk(sys_reset_n === 1'b0, "press asserts reset");
        // one extra cycle while the debounced request drops
        rel_chk(REL, REL + 1);
        tick(REL + 4);
        chk(sys_reset_n === 1'b1, "single request");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        tick(8);
        rst_b = 1'b1;
        tick(2);
        t_straps();
        t_supply();
        t_button();
        results();
    end
    // watchdog
    initial
    begin
        #100000;
        miscompares++;
        results();
    end
endmodule // srs_supervisor_tb_top
